// ### hdl/monitor_config_and_irq_control.sv
// Configuration, channel select and interrupt control of the hardware monitor
`timescale 1ns/100ps
`default_nettype none
`include "monitor_params.svh"
module monitor_config_and_irq_control
    import monitor_pkg::*;
#(
    parameter int RST_PULSE_CYCLES = `RST_PULSE_CYCLES
) (
    input wire logic mclk_i, // 100 MHz clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire logic [7:0] reg_addr_i, // Register pointer from serial interface
    input wire logic reg_wr_i, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_rd_i, // Read strobe, one cycle
    output logic [7:0] reg_rdata_o, // Read data, valid cycle after strobe
    input wire limit_events_t limit_evt_i, // Crossing pulses from conversion engine
    input wire logic over_temp_i, // Temperature over thermal limit
    input wire logic chassis_pin_i, // Chassis intrusion pin
    input wire logic [2:0] voltage_id_or_interrupt_select_pin_i, // Shared voltage-ID or interrupt pins
    input wire logic thermal_alarm_pin_i, // Thermal alarm pin level
    output logic thermal_alarm_pin_o, // Thermal alarm pin drive value
    output logic thermal_alarm_pin_oe_o, // Thermal alarm pin drive enable
    output logic int_n_o, // General interrupt output, active low
    output logic reset_n_o, // Outgoing reset pulse, active low
    output logic monitor_run_o, // Scanning and limit checking active
    output chan_mode_t chan_mode_o, // Channel function selection
    output logic defaults_restore_o // Restore pulse for other register groups
);
    initial begin
        if (RST_PULSE_CYCLES < 2) begin
            $error("RST_PULSE_CYCLES must be at least 2");
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    chan_mode_t chan_q;
    mon_cfg_t cfg_q;
    logic [7:0] stat_one_q, stat_two_q, mask_one_q, mask_two_q;
    logic [7:0] stat_one_d, stat_two_d, rdata_d;
    logic [7:0] rdata_q;
    logic [1:0] chassis_sync_q, thermal_alarm_pin_sync_q;
    logic [2:0] vid_s1_q, vid_s2_q;
    logic chassis_prev_q, int_n_q, thermal_alarm_pin_drv_q, restore_q, run_q;
    logic [1:0] thermal_alarm_pin_hist_q;
    logic pulse_n, pulse_busy;

    wire logic wr_chan = reg_wr_i && hit(reg_addr_i, `OFS_CHAN_SEL);
    wire logic wr_cfg = reg_wr_i && hit(reg_addr_i, `OFS_MON_CFG);
    wire logic wr_mask1 = reg_wr_i && hit(reg_addr_i, `OFS_MASK_ONE);
    wire logic wr_mask2 = reg_wr_i && hit(reg_addr_i, `OFS_MASK_TWO);
    wire logic rd_stat1 = reg_rd_i && hit(reg_addr_i, `OFS_STAT_ONE);
    wire logic rd_stat2 = reg_rd_i && hit(reg_addr_i, `OFS_STAT_TWO);
    wire logic restore = wr_cfg && reg_wdata_i[`CFG_RESTORE];
    wire logic fire_rst = wr_cfg && reg_wdata_i[`CFG_RESTORE] == 1'b0
        && reg_wdata_i[`CFG_RST_OUT] && !pulse_busy;

    // run only when started and not suppressed
    wire logic run = cfg_q.start && !cfg_q.int_suppress;

    wire logic chassis_evt = chassis_sync_q[1] && !chassis_prev_q;
    // pin low while not driven by this block
    // Own drive stays masked until the synchroniser has flushed it
    wire logic thermal_alarm_pin_ext_evt = !thermal_alarm_pin_sync_q[1] && !thermal_alarm_pin_drv_q && !(|thermal_alarm_pin_hist_q);
    // engine events count only while running
    wire logic [7:0] evt_one = run ? limit_evt_i.stat_one : 8'h00;
    wire logic [7:0] evt_two_eng = run ? (limit_evt_i.stat_two & 8'hC3) : 8'h00;
    wire logic [7:0] evt_two = evt_two_eng | {2'b00, thermal_alarm_pin_ext_evt, chassis_evt, 4'h0};

    // interrupt inputs only in interrupt mode
    wire logic [2:0] ext_irq = (~vid_s2_q) & chan_q.ext_interrupt_enable
        & {3{chan_q.voltage_id_or_interrupt_select}};

    wire logic [7:0] pend_one = stat_one_q & ~mask_one_q;
    wire logic [7:0] pend_two = stat_two_q & ~mask_two_q;
    // start bit does not enter this term
    wire logic int_assert = cfg_q.int_enable && !cfg_q.int_suppress
        && ((|pend_one) || (|pend_two) || (|ext_irq));
    wire logic thermal_alarm_pin_assert = cfg_q.thermal_alarm_pin_enable && !cfg_q.thermal_alarm_suppress
        && over_temp_i;

    // Set wins over a clear by read
    always_comb begin
        stat_one_d = (rd_stat1 ? 8'h00 : stat_one_q) | evt_one;
        stat_two_d = ((rd_stat2 ? 8'h00 : stat_two_q) | evt_two) & `ST2_RESERVED_MASK;
        if (restore) begin
            stat_one_d = `RST_STAT;
            stat_two_d = `RST_STAT;
        end
    end

    // Register read selection
    always_comb begin
        if (hit(reg_addr_i, `OFS_CHAN_SEL)) begin
            rdata_d = chan_q;
        end else if (hit(reg_addr_i, `OFS_MON_CFG)) begin
            rdata_d = {1'b0, cfg_q[6:5], pulse_busy, cfg_q[3:0]};
        end else if (hit(reg_addr_i, `OFS_STAT_ONE)) begin
            rdata_d = stat_one_q;
        end else if (hit(reg_addr_i, `OFS_STAT_TWO)) begin
            rdata_d = stat_two_q;
        end else if (hit(reg_addr_i, `OFS_MASK_ONE)) begin
            rdata_d = mask_one_q;
        end else if (hit(reg_addr_i, `OFS_MASK_TWO)) begin
            rdata_d = mask_two_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chassis_sync_q <= 2'b00;
            thermal_alarm_pin_sync_q <= 2'b11;
            vid_s1_q <= 3'h7;
            vid_s2_q <= 3'h7;
            chassis_prev_q <= 1'b0;
        end else begin
            chassis_sync_q <= {chassis_sync_q[0], chassis_pin_i};
            thermal_alarm_pin_sync_q <= {thermal_alarm_pin_sync_q[0], thermal_alarm_pin_i};
            vid_s1_q <= voltage_id_or_interrupt_select_pin_i;
            vid_s2_q <= vid_s1_q;
            chassis_prev_q <= chassis_sync_q[1];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_q <= `RST_CHAN_SEL;
            cfg_q <= `RST_MON_CFG;
            mask_one_q <= `RST_MASK;
            mask_two_q <= `RST_MASK;
        end else if (restore) begin
            cfg_q <= `RST_MON_CFG;
            mask_one_q <= `RST_MASK;
            mask_two_q <= `RST_MASK;
        end else begin
            if (wr_chan) begin
                chan_q <= reg_wdata_i;
            end
            if (wr_cfg) begin
                cfg_q <= {1'b0, reg_wdata_i[6:5], 1'b0, reg_wdata_i[3:0]};
            end
            if (wr_mask1) begin
                mask_one_q <= reg_wdata_i;
            end
            if (wr_mask2) begin
                mask_two_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_one_q <= `RST_STAT;
            stat_two_q <= `RST_STAT;
            rdata_q <= 8'h00;
            int_n_q <= 1'b1;
            thermal_alarm_pin_drv_q <= 1'b0;
            thermal_alarm_pin_hist_q <= 2'b00;
            restore_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            stat_one_q <= stat_one_d;
            stat_two_q <= stat_two_d;
            rdata_q <= reg_rd_i ? rdata_d : rdata_q;
            int_n_q <= !int_assert;
            thermal_alarm_pin_drv_q <= thermal_alarm_pin_assert;
            thermal_alarm_pin_hist_q <= {thermal_alarm_pin_hist_q[0], thermal_alarm_pin_drv_q};
            restore_q <= restore;
            run_q <= run;
        end
    end

    reset_pulse_gen #(
        .PULSE_CYCLES(RST_PULSE_CYCLES)
    ) u_rst_pulse (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .fire_i(fire_rst),
        .pulse_n_o(pulse_n),
        .busy_o(pulse_busy)
    );

    assign reg_rdata_o = rdata_q;
    assign int_n_o = int_n_q;
    assign thermal_alarm_pin_o = 1'b0;
    assign thermal_alarm_pin_oe_o = thermal_alarm_pin_drv_q;
    assign reset_n_o = pulse_n;
    assign monitor_run_o = run_q;
    assign chan_mode_o = chan_q;
    assign defaults_restore_o = restore_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_pulse_req;
        fire_rst;
    endsequence
    sequence s_pulse_run;
        ##1 (!reset_n_o)[*8];
    endsequence

    a_reset_pulse_low: assert property (s_pulse_req |-> s_pulse_run)
        else $error("reset pulse not held low");
    a_int_follows_pend: assert property (
        (cfg_q.int_enable && !cfg_q.int_suppress && (|pend_one)) |=> !int_n_o)
        else $error("interrupt not asserted for pending status");
    a_int_disabled: assert property (!cfg_q.int_enable |=> int_n_o)
        else $error("interrupt driven while disabled");
    a_int_clear_rel: assert property (cfg_q.int_suppress |=> int_n_o && !monitor_run_o)
        else $error("int clear did not release output");
    a_start_keeps_int: assert property (
        (wr_cfg && !reg_wdata_i[0] && !restore && !int_n_o && cfg_q.int_enable
         && !reg_wdata_i[3] && reg_wdata_i[1] && (|pend_one) && !rd_stat1)
        |=> ##1 !int_n_o)
        else $error("start clear released interrupt");
    a_mask_blocks: assert property (
        (cfg_q.int_enable && (stat_one_q & ~mask_one_q) == 8'h00 && pend_two == 8'h00
         && ext_irq == 3'h0) |=> int_n_o)
        else $error("masked status drove interrupt");
    a_thermal_alarm_pin_suppress: assert property (cfg_q.thermal_alarm_suppress |=> !thermal_alarm_pin_oe_o)
        else $error("thermal output driven while suppressed");
    a_restore_defaults: assert property (restore |=> cfg_q == `RST_MON_CFG
        && stat_one_q == 8'h00 && mask_one_q == 8'h00 && defaults_restore_o)
        else $error("defaults not restored");
    a_status_sets: assert property ((run && limit_evt_i.stat_one[0] && !restore) |=> stat_one_q[0])
        else $error("status bit not set");
    a_chassis_sets: assert property (chassis_evt && !restore |=> stat_two_q[`ST2_CHASSIS])
        else $error("chassis flag not set");
    a_fan_status: assert property (
        (run && limit_evt_i.stat_one[6] && !restore) |=> stat_one_q[6])
        else $error("fan or analog status not set");
    a_diode_fault: assert property (
        (run && limit_evt_i.stat_two[7] && !restore) |=> stat_two_q[7])
        else $error("diode fault status not set");
    a_thermal_alarm_pin_flag: assert property (
        (thermal_alarm_pin_ext_evt && !restore) |=> stat_two_q[`ST2_THERMAL_ALARM_PIN])
        else $error("thermal pin flag not set");
    a_thermal_alarm_pin_drives: assert property (
        (cfg_q.thermal_alarm_pin_enable && !cfg_q.thermal_alarm_suppress && over_temp_i)
        |=> thermal_alarm_pin_oe_o)
        else $error("thermal output not driven");
    a_ext_irq_asserts: assert property (
        (cfg_q.int_enable && !cfg_q.int_suppress && (|ext_irq)) |=> !int_n_o)
        else $error("external interrupt input ignored");
    a_vid_mode_quiet: assert property (
        (!chan_q.voltage_id_or_interrupt_select && pend_one == 8'h00 && pend_two == 8'h00)
        |=> int_n_o)
        else $error("voltage-ID pins raised an interrupt");
    a_run_follows: assert property (
        (cfg_q.start && !cfg_q.int_suppress) |=> monitor_run_o)
        else $error("monitoring not running after start");
    a_standby: assert property (!cfg_q.start |=> !monitor_run_o)
        else $error("monitoring running in standby");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    a_stat_read_clear: assert property (
        (rd_stat1 && !run && !restore) |=> stat_one_q == 8'h00)
        else $error("status one not cleared by read");

    // Length of the running reset pulse, for the minimum width check
    logic [31:0] low_len_q;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_len_q <= 32'h0;
        end else if (!reset_n_o) begin
            low_len_q <= low_len_q + 32'h1;
        end else begin
            low_len_q <= 32'h0;
        end
    end

    a_reset_pulse_len: assert property (
        $rose(reset_n_o) |-> low_len_q >= 32'(RST_PULSE_CYCLES))
        else $error("reset pulse shorter than minimum");
endmodule // monitor_config_and_irq_control
`default_nettype wire

// ### include/monitor_params.svh
// Offsets, field positions, reset values and timing counts of the monitor control block
`ifndef MONITOR_PARAMS_SVH
`define MONITOR_PARAMS_SVH

`define OFS_CHAN_SEL 8'h16
`define OFS_MON_CFG 8'h40
`define OFS_STAT_ONE 8'h41
`define OFS_STAT_TWO 8'h42
`define OFS_MASK_ONE 8'h43
`define OFS_MASK_TWO 8'h44

`define RST_CHAN_SEL 8'h00
`define RST_MON_CFG 8'h08
`define RST_STAT 8'h00
`define RST_MASK 8'h00

`define CFG_START 0
`define CFG_INT_EN 1
`define CFG_THERMAL_ALARM_PIN_EN 2
`define CFG_INT_CLR 3
`define CFG_RST_OUT 4
`define CFG_THERMAL_ALARM_PIN_CLR 6
`define CFG_RESTORE 7

`define ST2_CHASSIS 4
`define ST2_THERMAL_ALARM_PIN 5
`define ST2_RESERVED_MASK 8'hF3

`define CLK_MHZ 100
`define RST_PULSE_MS 20
`define RST_PULSE_CYCLES (`RST_PULSE_MS * 1000 * `CLK_MHZ)

`endif

// ### include/monitor_pkg.sv
// Types shared by the monitor control block
package monitor_pkg;
    typedef struct packed {
        logic voltage_id_or_interrupt_select;
        logic [2:0] ext_interrupt_enable;
        logic supply_range_5v;
        logic second_remote_diode;
        logic tach_two_or_analog_two;
        logic tach_one_or_analog_one;
    } chan_mode_t;

    typedef struct packed {
        logic defaults_restore;
        logic thermal_alarm_suppress;
        logic reserved5;
        logic reset_out;
        logic int_suppress;
        logic thermal_alarm_pin_enable;
        logic int_enable;
        logic start;
    } mon_cfg_t;

    typedef struct packed {
        logic [7:0] stat_one;
        logic [7:0] stat_two;
    } limit_events_t;

    typedef enum logic [0:0] {
        PULSE_IDLE = 1'b0,
        PULSE_LOW = 1'b1
    } pulse_state_t;
endpackage

// ### hdl/reset_pulse_gen.sv
// Timed active-low pulse generator for the outgoing reset
`timescale 1ns/100ps
`default_nettype none
module reset_pulse_gen
    import monitor_pkg::*;
#(
    parameter int PULSE_CYCLES = 2000000
) (
    input wire logic mclk_i, // System clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire logic fire_i, // One-cycle request to start a pulse
    output logic pulse_n_o, // Pulse output, active low
    output logic busy_o // High while the pulse runs
);
    initial begin
        if (PULSE_CYCLES < 2) begin
            $error("PULSE_CYCLES must be at least 2");
        end
    end

    pulse_state_t state_q;
    logic [31:0] cnt_q;
    logic pulse_n_q;
    wire logic done = (cnt_q == 32'(PULSE_CYCLES - 1));

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= PULSE_IDLE;
            cnt_q <= 32'h0;
            pulse_n_q <= 1'b1;
        end else begin
            case (state_q)
                PULSE_IDLE: begin
                    cnt_q <= 32'h0;
                    if (fire_i) begin
                        state_q <= PULSE_LOW;
                        pulse_n_q <= 1'b0;
                    end
                end
                PULSE_LOW: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (done) begin
                        state_q <= PULSE_IDLE;
                        pulse_n_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= PULSE_IDLE;
                    pulse_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Pulse leaves the block straight from a flip-flop
    assign pulse_n_o = pulse_n_q;
    assign busy_o = (state_q == PULSE_LOW);
endmodule // reset_pulse_gen
`default_nettype wire

// ### sim/thermal_pin_partner.sv
// Far-side model of the open-drain thermal alarm wire
`timescale 1ns/100ps
`default_nettype none
module thermal_pin_partner (
    input wire logic drv_i, // Drive value from the block
    input wire logic oe_i, // Drive enable from the block
    input wire logic pull_low_i, // Outside circuit pulling the wire low
    output logic pin_o // Resolved wire level
);
    assign pin_o = (oe_i ? drv_i : 1'b1) & ~pull_low_i;
endmodule // thermal_pin_partner
`default_nettype wire

// ### sim/monitor_config_and_irq_control_tb.sv
// Self-checking bench for the monitor configuration and interrupt block
`timescale 1ns/100ps
`default_nettype none
module monitor_config_and_irq_control_tb;
    import monitor_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    limit_events_t evt = 16'h0000;
    logic over_temp = 1'b0;
    logic chassis = 1'b0;
    logic [2:0] vid = 3'h7;
    logic pull_low = 1'b0;
    logic pin_lvl, pin_drv, pin_oe, int_n, rst_n, run, restore;
    chan_mode_t mode;
    int err_count = 0;
    int checks = 0;
    int low_cnt = 0;
    int rst_cnt = 0;

    always #5 mclk_i = ~mclk_i;

    monitor_config_and_irq_control #(.RST_PULSE_CYCLES(20)) monitor_config_and_irq_control_inst (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .limit_evt_i(evt),
        .over_temp_i(over_temp), .chassis_pin_i(chassis), .voltage_id_or_interrupt_select_pin_i(vid),
        .thermal_alarm_pin_i(pin_lvl), .thermal_alarm_pin_o(pin_drv),
        .thermal_alarm_pin_oe_o(pin_oe), .int_n_o(int_n), .reset_n_o(rst_n),
        .monitor_run_o(run), .chan_mode_o(mode), .defaults_restore_o(restore)
    );

    thermal_pin_partner thermal_pin_partner_inst (
        .drv_i(pin_drv), .oe_i(pin_oe), .pull_low_i(pull_low), .pin_o(pin_lvl)
    );

    // Counts cycles of the outgoing reset pulse and restore pulses
    always @(negedge mclk_i) begin
        if (arst_n_i && rst_n === 1'b0) low_cnt++;
        if (arst_n_i && restore === 1'b1) rst_cnt++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        addr = a;
        rd = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
        chk(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic pulse(input logic [15:0] e);
        @(negedge mclk_i);
        evt = e;
        @(negedge mclk_i);
        evt = 16'h0000;
    endtask

    task automatic results();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin : watchdog
        #300000;
        err_count++;
        results();
    end

    initial begin
        tick(4);
        arst_n_i = 1'b1;
        rd_chk(8'h16, 8'h00); // reset value
        rd_chk(8'h40, 8'h08); // reset value
        rd_chk(8'h41, 8'h00); // reset value
        rd_chk(8'h42, 8'h00); // reset value
        rd_chk(8'h43, 8'h00); // reset value
        rd_chk(8'h44, 8'h00); // reset value
        rd_chk(8'h45, 8'h00); // unmapped
        wr_reg(8'h16, 8'h0F);
        rd_chk(8'h16, 8'h0F);
        chk(mode, 8'h0F);
        wr_reg(8'h41, 8'hFF); // read-only status
        rd_chk(8'h41, 8'h00); // read-only status
        // Masks programmed before start, all status interrupts blocked
        wr_reg(8'h43, 8'hFF);
        wr_reg(8'h44, 8'hFF);
        wr_reg(8'h40, 8'h03);
        tick(1);
        chk(run, 8'h01);
        pulse(16'hFFC3);
        tick(3);
        chk(int_n, 8'h01);
        rd_chk(8'h43, 8'hFF);
        rd_chk(8'h41, 8'hFF);
        rd_chk(8'h42, 8'hC3);
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h44, 8'h00);
        pulse(16'h4000);
        tick(3);
        chk(int_n, 8'h00);
        wr_reg(8'h40, 8'h02);
        tick(2);
        chk(int_n, 8'h00);
        chk(run, 8'h00);
        wr_reg(8'h40, 8'h0A);
        tick(2);
        chk(int_n, 8'h01);
        rd_chk(8'h41, 8'h40);
        // Interrupt output disabled, then enabled with a status pending
        wr_reg(8'h40, 8'h01);
        pulse(16'h0001);
        tick(3);
        chk(int_n, 8'h01);
        wr_reg(8'h40, 8'h03);
        tick(2);
        chk(int_n, 8'h00);
        rd_chk(8'h42, 8'h01);
        tick(2);
        chk(int_n, 8'h01);
        // Shared pins as interrupt inputs
        wr_reg(8'h40, 8'h02);
        wr_reg(8'h16, 8'h10);
        vid = 3'h6;
        tick(5);
        chk(int_n, 8'h01);
        wr_reg(8'h16, 8'h90);
        tick(5);
        chk(int_n, 8'h00);
        vid = 3'h7;
        tick(5);
        chk(int_n, 8'h01);
        // Thermal output enable and suppress
        over_temp = 1'b1;
        wr_reg(8'h40, 8'h04);
        tick(2);
        chk(pin_oe, 8'h01);
        chk(pin_lvl, 8'h00);
        wr_reg(8'h40, 8'h44);
        tick(2);
        chk(pin_oe, 8'h00);
        rd_chk(8'h42, 8'h00);
        over_temp = 1'b0;
        pull_low = 1'b1;
        tick(4);
        pull_low = 1'b0;
        chassis = 1'b1;
        tick(4);
        rd_chk(8'h42, 8'h30);
        low_cnt = 0;
        wr_reg(8'h40, 8'h10);
        rd_chk(8'h40, 8'h10);
        tick(28);
        chk(low_cnt[7:0], 8'h14);
        rd_chk(8'h40, 8'h00);
        wr_reg(8'h43, 8'h55);
        wr_reg(8'h16, 8'h33);
        wr_reg(8'h40, 8'h07);
        rst_cnt = 0;
        wr_reg(8'h40, 8'h80);
        tick(2);
        chk(rst_cnt[7:0], 8'h01);
        rd_chk(8'h40, 8'h08);
        rd_chk(8'h43, 8'h00);
        rd_chk(8'h16, 8'h33);
        results();
    end
endmodule // monitor_config_and_irq_control_tb
`default_nettype wire
